// [rtl/ieb_irq_bank.sv]
// Interrupt enable and priority register bank with request gating
`timescale 1ns/1ps
`default_nettype none
`include "ieb_consts.svh"

module ieb_irq_bank
  import ieb_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Special function register byte port
  input wire ieb_sfr_req_s i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // Bit-addressable port
  input wire ieb_bit_req_s i_bit,
  output logic o_bit_rdata,
  // Peripheral pending flags
  input wire ieb_pending_s i_pend,
  // Core interrupt interface
  input wire logic i_take,
  input wire logic i_reti,
  output logic [`IEB_NUM_SRC-1:0] o_req,
  output logic [`IEB_NUM_SRC-1:0] o_req_high,
  output ieb_grant_s o_grant
);

  typedef struct packed {
    logic [7:0] main_interrupt_enable;
    logic [7:0] main_interrupt_priority;
    logic [7:0] extended_enable_first;
    logic [7:0] extended_priority_first;
    ieb_svc_e svc;
    logic [`IEB_NUM_SRC-1:0] req;
    logic [`IEB_NUM_SRC-1:0] req_high;
    ieb_grant_s grant;
    logic [7:0] rdata;
    logic hit;
    logic bit_rdata;
  } ieb_state_s;

  ieb_state_s st_reg;
  ieb_state_s st_next;

  // Main and first extended bytes share one source order
  function automatic logic [`IEB_NUM_SRC-1:0] src_map(
    input logic [7:0] main_byte,
    input logic [7:0] ext_byte
  );
    src_map = {ext_byte, main_byte[6:0]};
  endfunction

  // Bit address falls inside an 8-aligned register
  function automatic logic bit_hit(
    input logic [7:0] bit_addr,
    input logic [7:0] base
  );
    bit_hit = (bit_addr[7:3] == base[7:3]);
  endfunction

  // Pending flags folded into one line per source
  function automatic logic [`IEB_NUM_SRC-1:0] src_pending(
    input ieb_pending_s p
  );
    logic [`IEB_NUM_SRC-1:0] v;
    v = '0;
    v[IEB_SRC_EXT_PIN_A] = p.ext_pin_a_input;
    v[IEB_SRC_TIMER_ZERO] = p.timer_zero_overflow;
    v[IEB_SRC_EXT_PIN_B] = p.ext_pin_b_input;
    v[IEB_SRC_TIMER_ONE] = p.timer_one_overflow;
    v[IEB_SRC_ASYNC_SERIAL] = p.async_serial_req;
    v[IEB_SRC_TIMER_B] = p.timer_b_low_overflow | p.timer_b_high_overflow;
    v[IEB_SRC_SERIAL_PERIPH_A] = p.serial_periph_a_req;
    v[IEB_SRC_TWO_WIRE] = p.two_wire_req;
    v[IEB_SRC_CLOCK_ALARM] = p.clock_alarm_req;
    v[IEB_SRC_WINDOW_COMPARE] = p.window_hit_flag;
    v[IEB_SRC_CONVERSION_DONE] = p.conversion_done_flag;
    v[IEB_SRC_COUNTER_ARRAY] = p.counter_array_req;
    v[IEB_SRC_COMPARATOR_A] = p.comparator_a_rise_flag | p.comparator_a_fall_flag;
    v[IEB_SRC_COMPARATOR_B] = p.comparator_b_rise_flag | p.comparator_b_fall_flag;
    v[IEB_SRC_TIMER_C] = p.timer_c_low_overflow | p.timer_c_high_overflow;
    return v;
  endfunction

  logic [`IEB_NUM_SRC-1:0] enable_vec;
  logic [`IEB_NUM_SRC-1:0] prio_vec;
  logic [`IEB_NUM_SRC-1:0] pend_vec;
  logic [`IEB_NUM_SRC-1:0] masked_vec;
  logic allow_low;
  logic allow_high;
  ieb_grant_s pick;

  // Flags are only looked at here, never cleared, so they stand regardless of enables
  assign pend_vec = src_pending(i_pend);
  assign enable_vec = src_map(st_reg.main_interrupt_enable, st_reg.extended_enable_first);
  assign prio_vec = src_map(st_reg.main_interrupt_priority, st_reg.extended_priority_first);

  // Global gate overrides every individual mask
  assign masked_vec = pend_vec & enable_vec
    & {`IEB_NUM_SRC{st_reg.main_interrupt_enable[`IEB_GLOBAL_IRQ_GATE]}};

  // High may cut into low service; high service is never cut into
  assign allow_low = (st_reg.svc == IEB_SVC_IDLE);
  assign allow_high = (st_reg.svc == IEB_SVC_IDLE) || (st_reg.svc == IEB_SVC_LOW);

  ieb_prio_pick u_pick (
    .i_req(masked_vec),
    .i_prio(prio_vec),
    .i_allow_low(allow_low),
    .i_allow_high(allow_high),
    .o_grant(pick)
  );

  always_comb
  begin
    st_next = st_reg;

    // Bit writes first so a byte write in the same cycle wins
    if (i_bit.wr && bit_hit(i_bit.addr, `IEB_ADDR_MAIN_ENABLE))
    begin
      st_next.main_interrupt_enable[i_bit.addr[2:0]] = i_bit.value;
    end
    else if (i_bit.wr && bit_hit(i_bit.addr, `IEB_ADDR_MAIN_PRIO))
    begin
      st_next.main_interrupt_priority[i_bit.addr[2:0]] = i_bit.value;
    end

    if (i_sfr.wr && i_sfr.addr == `IEB_ADDR_MAIN_ENABLE)
    begin
      st_next.main_interrupt_enable = i_sfr.wdata;
    end
    else if (i_sfr.wr && i_sfr.addr == `IEB_ADDR_MAIN_PRIO)
    begin
      st_next.main_interrupt_priority = i_sfr.wdata;
    end
    else if (i_sfr.wr && i_sfr.addr == `IEB_ADDR_EXT_ENABLE_FIRST)
    begin
      st_next.extended_enable_first = i_sfr.wdata;
    end
    else if (i_sfr.wr && i_sfr.addr == `IEB_ADDR_EXT_PRIO_FIRST)
    begin
      st_next.extended_priority_first = i_sfr.wdata;
    end

    // Reserved bit is read-only; a stray write cannot move it
    st_next.main_interrupt_priority[`IEB_PRIO_RESERVED] = 1'b1;

    // Byte read answer, one cycle after the strobe
    st_next.hit = 1'b0;
    st_next.rdata = 8'h00;
    if (i_sfr.rd && i_sfr.addr == `IEB_ADDR_MAIN_ENABLE)
    begin
      st_next.hit = 1'b1;
      st_next.rdata = st_reg.main_interrupt_enable;
    end
    else if (i_sfr.rd && i_sfr.addr == `IEB_ADDR_MAIN_PRIO)
    begin
      st_next.hit = 1'b1;
      st_next.rdata = st_reg.main_interrupt_priority;
    end
    else if (i_sfr.rd && i_sfr.addr == `IEB_ADDR_EXT_ENABLE_FIRST)
    begin
      st_next.hit = 1'b1;
      st_next.rdata = st_reg.extended_enable_first;
    end
    else if (i_sfr.rd && i_sfr.addr == `IEB_ADDR_EXT_PRIO_FIRST)
    begin
      st_next.hit = 1'b1;
      st_next.rdata = st_reg.extended_priority_first;
    end

    st_next.bit_rdata = 1'b0;
    if (i_bit.rd && bit_hit(i_bit.addr, `IEB_ADDR_MAIN_ENABLE))
    begin
      st_next.bit_rdata = st_reg.main_interrupt_enable[i_bit.addr[2:0]];
    end
    else if (i_bit.rd && bit_hit(i_bit.addr, `IEB_ADDR_MAIN_PRIO))
    begin
      st_next.bit_rdata = st_reg.main_interrupt_priority[i_bit.addr[2:0]];
    end

    // Requests sampled every cycle, tagged with their level
    st_next.req = masked_vec;
    st_next.req_high = masked_vec & prio_vec;

    // Service level tracking; a take beats a return in the same cycle
    case (st_reg.svc)
      IEB_SVC_IDLE:
      begin
        if (i_take && st_reg.grant.valid)
        begin
          st_next.svc = st_reg.grant.high ? IEB_SVC_HIGH : IEB_SVC_LOW;
        end
      end
      IEB_SVC_LOW:
      begin
        if (i_take && st_reg.grant.valid && st_reg.grant.high)
        begin
          st_next.svc = IEB_SVC_NESTED;
        end
        else if (i_reti)
        begin
          st_next.svc = IEB_SVC_IDLE;
        end
      end
      IEB_SVC_HIGH:
      begin
        if (i_reti)
        begin
          st_next.svc = IEB_SVC_IDLE;
        end
      end
      IEB_SVC_NESTED:
      begin
        if (i_reti)
        begin
          st_next.svc = IEB_SVC_LOW;
        end
      end
      default:
      begin
        st_next.svc = IEB_SVC_IDLE;
      end
    endcase

    // Withdraw the offer while the level changes, so a stale grant is never taken twice
    st_next.grant = pick;
    if (i_take || i_reti)
    begin
      st_next.grant = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_reg <= '0;
      st_reg.main_interrupt_enable <= `IEB_RST_MAIN_ENABLE;
      st_reg.main_interrupt_priority <= `IEB_RST_MAIN_PRIO;
      st_reg.extended_enable_first <= `IEB_RST_EXT_ENABLE_FIRST;
      st_reg.extended_priority_first <= `IEB_RST_EXT_PRIO_FIRST;
      st_reg.svc <= IEB_SVC_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_sfr_rdata = st_reg.rdata;
  assign o_sfr_hit = st_reg.hit;
  assign o_bit_rdata = st_reg.bit_rdata;
  assign o_req = st_reg.req;
  assign o_req_high = st_reg.req_high;
  assign o_grant = st_reg.grant;

  chk_gate_blocks_all: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !st_reg.main_interrupt_enable[`IEB_GLOBAL_IRQ_GATE] |=> (o_req == '0))
    else $error("request passed with global gate off");

  chk_ext_a_passes: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    st_reg.main_interrupt_enable[`IEB_GLOBAL_IRQ_GATE]
    && st_reg.main_interrupt_enable[`IEB_EXT_PIN_A_IRQ_ON]
    && i_pend.ext_pin_a_input |=> o_req[IEB_SRC_EXT_PIN_A])
    else $error("enabled external pin a request lost");

  chk_timer_b_either: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    st_reg.main_interrupt_enable[`IEB_GLOBAL_IRQ_GATE]
    && st_reg.main_interrupt_enable[`IEB_TIMER_B_IRQ_ON]
    && (i_pend.timer_b_low_overflow || i_pend.timer_b_high_overflow)
    |=> o_req[IEB_SRC_TIMER_B])
    else $error("timer b overflow not requested");

  chk_serial_masked: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !st_reg.main_interrupt_enable[`IEB_SERIAL_PERIPH_A_IRQ_ON]
    |=> !o_req[IEB_SRC_SERIAL_PERIPH_A])
    else $error("masked serial peripheral request passed");

  chk_array_masked: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !enable_vec[IEB_SRC_COUNTER_ARRAY] |=> !o_req[IEB_SRC_COUNTER_ARRAY])
    else $error("masked counter array request passed");

  chk_two_wire_passes: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    st_reg.main_interrupt_enable[`IEB_GLOBAL_IRQ_GATE] && enable_vec[IEB_SRC_TWO_WIRE]
    && pend_vec[IEB_SRC_TWO_WIRE] |=> o_req[IEB_SRC_TWO_WIRE])
    else $error("enabled two-wire request lost");

  chk_rsvd_prio_one: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    st_reg.main_interrupt_priority[`IEB_PRIO_RESERVED])
    else $error("reserved priority bit not one");

  chk_prio_tag_follows: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    1'b1 |=> (o_req_high == (o_req & $past(prio_vec))))
    else $error("request level tag mismatch");

  chk_high_not_cut: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (st_reg.svc == IEB_SVC_HIGH || st_reg.svc == IEB_SVC_NESTED) |=> !o_grant.valid)
    else $error("grant offered during high service");

  chk_low_cut_high: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (st_reg.svc == IEB_SVC_LOW) ##1 (st_reg.svc == IEB_SVC_LOW && o_grant.valid)
    |-> o_grant.high)
    else $error("low grant offered during low service");

  // Grant and request tags come from the same edge, so they can be compared directly
  chk_low_yields_high: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_grant.valid && !o_grant.high |-> (o_req_high == '0))
    else $error("low grant offered over a high request");

  chk_tie_low_index: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_grant.valid && o_grant.high
    |-> ((o_req_high & ((15'h0001 << o_grant.src) - 15'h0001)) == '0))
    else $error("high tie not won by lowest index");

  chk_enable_write: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_sfr.wr && i_sfr.addr == `IEB_ADDR_EXT_ENABLE_FIRST
    |=> st_reg.extended_enable_first == $past(i_sfr.wdata))
    else $error("first extended enable write lost");

endmodule
`default_nettype wire

// [rtl/ieb_consts.svh]
// Constants for the interrupt enable and priority bank
`ifndef IEB_CONSTS_SVH
`define IEB_CONSTS_SVH

// Special function register addresses
`define IEB_ADDR_MAIN_ENABLE 8'hA8
`define IEB_ADDR_MAIN_PRIO 8'hB8
`define IEB_ADDR_EXT_ENABLE_FIRST 8'hE6
`define IEB_ADDR_EXT_PRIO_FIRST 8'hF6

// Reset values
`define IEB_RST_MAIN_ENABLE 8'h00
`define IEB_RST_MAIN_PRIO 8'h80
`define IEB_RST_EXT_ENABLE_FIRST 8'h00
`define IEB_RST_EXT_PRIO_FIRST 8'h00

// Field positions in the main enable and main priority registers
`define IEB_GLOBAL_IRQ_GATE 7
`define IEB_PRIO_RESERVED 7
`define IEB_SERIAL_PERIPH_A_IRQ_ON 6
`define IEB_TIMER_B_IRQ_ON 5
`define IEB_EXT_PIN_A_IRQ_ON 0

// Source count and index width
`define IEB_NUM_SRC 15
`define IEB_SRC_W 4

`endif

// [rtl/ieb_pkg.sv]
// Types shared by the interrupt enable and priority bank
package ieb_pkg;

  // Sources in vector-table order; a lower index wins a tie
  typedef enum logic [3:0] {
    IEB_SRC_EXT_PIN_A,
    IEB_SRC_TIMER_ZERO,
    IEB_SRC_EXT_PIN_B,
    IEB_SRC_TIMER_ONE,
    IEB_SRC_ASYNC_SERIAL,
    IEB_SRC_TIMER_B,
    IEB_SRC_SERIAL_PERIPH_A,
    IEB_SRC_TWO_WIRE,
    IEB_SRC_CLOCK_ALARM,
    IEB_SRC_WINDOW_COMPARE,
    IEB_SRC_CONVERSION_DONE,
    IEB_SRC_COUNTER_ARRAY,
    IEB_SRC_COMPARATOR_A,
    IEB_SRC_COMPARATOR_B,
    IEB_SRC_TIMER_C
  } ieb_src_e;

  typedef enum logic [1:0] {
    IEB_SVC_IDLE,
    IEB_SVC_LOW,
    IEB_SVC_HIGH,
    IEB_SVC_NESTED
  } ieb_svc_e;

  typedef struct packed {
    logic timer_c_high_overflow;
    logic timer_c_low_overflow;
    logic comparator_b_rise_flag;
    logic comparator_b_fall_flag;
    logic comparator_a_rise_flag;
    logic comparator_a_fall_flag;
    logic counter_array_req;
    logic conversion_done_flag;
    logic window_hit_flag;
    logic clock_alarm_req;
    logic two_wire_req;
    logic serial_periph_a_req;
    logic timer_b_high_overflow;
    logic timer_b_low_overflow;
    logic async_serial_req;
    logic timer_one_overflow;
    logic ext_pin_b_input;
    logic timer_zero_overflow;
    logic ext_pin_a_input;
  } ieb_pending_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ieb_sfr_req_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic value;
  } ieb_bit_req_s;

  typedef struct packed {
    logic valid;
    logic high;
    ieb_src_e src;
  } ieb_grant_s;

endpackage

// [rtl/ieb_prio_pick.sv]
// Two-level fixed-order pick among masked interrupt requests
`timescale 1ns/1ps
`default_nettype none
`include "ieb_consts.svh"

module ieb_prio_pick
  import ieb_pkg::*;
(
  // Masked requests and their priority tags
  input wire logic [`IEB_NUM_SRC-1:0] i_req,
  input wire logic [`IEB_NUM_SRC-1:0] i_prio,
  // Levels the core may accept now
  input wire logic i_allow_low,
  input wire logic i_allow_high,
  // Winner
  output ieb_grant_s o_grant
);

  logic [`IEB_NUM_SRC-1:0] hi_req;
  logic [`IEB_NUM_SRC-1:0] lo_req;

  assign hi_req = i_req & i_prio & {`IEB_NUM_SRC{i_allow_high}};
  assign lo_req = i_req & ~i_prio & {`IEB_NUM_SRC{i_allow_low}};

  always_comb
  begin
    o_grant = '0;
    // Walk downward so the lowest vector index is left standing
    for (int i = `IEB_NUM_SRC - 1; i >= 0; i--)
    begin
      if (lo_req[i])
      begin
        o_grant.valid = 1'b1;
        o_grant.high = 1'b0;
        o_grant.src = ieb_src_e'(i[`IEB_SRC_W-1:0]);
      end
    end
    for (int i = `IEB_NUM_SRC - 1; i >= 0; i--)
    begin
      if (hi_req[i])
      begin
        o_grant.valid = 1'b1;
        o_grant.high = 1'b1;
        o_grant.src = ieb_src_e'(i[`IEB_SRC_W-1:0]);
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/ieb_core_model.sv]
// Core-side model: takes offered grants and returns from service on command
`timescale 1ns/1ps
`default_nettype none

module ieb_core_model
  import ieb_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Grant from the bank and bench controls
  input wire ieb_grant_s i_grant,
  input wire logic i_auto,
  input wire logic i_ret,
  // Core actions
  output logic o_take,
  output logic o_reti,
  output ieb_src_e o_last_src,
  output logic [1:0] o_depth
);
  logic take_now;
  logic reti_now;

  // Holding off while a take or return is in flight avoids taking one grant twice
  assign take_now = i_auto && i_grant.valid && !o_take && !o_reti;
  // A return only while something is in service, never beside a take
  assign reti_now = i_ret && !take_now && (o_depth != 2'h0);

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_take <= 1'h0;
      o_reti <= 1'h0;
      o_last_src <= IEB_SRC_EXT_PIN_A;
      o_depth <= 2'h0;
    end
    else
    begin
      o_take <= take_now;
      o_reti <= reti_now;
      if (take_now)
      begin
        o_last_src <= i_grant.src;
        o_depth <= o_depth + 2'h1;
      end
      else if (reti_now)
      begin
        o_depth <= o_depth - 2'h1;
      end
    end
  end
endmodule

`default_nettype wire

// [testbench/ieb_irq_bank_tb.sv]
// Self-checking bench for the interrupt enable and priority bank
`timescale 1ns/1ps
`default_nettype none
`include "ieb_consts.svh"

module ieb_irq_bank_tb
  import ieb_pkg::*;
;
  localparam logic [7:0] ADDRS [4] = '{`IEB_ADDR_MAIN_ENABLE, `IEB_ADDR_MAIN_PRIO,
    `IEB_ADDR_EXT_ENABLE_FIRST, `IEB_ADDR_EXT_PRIO_FIRST};
  localparam logic [7:0] RSTS [4] = '{8'h00, 8'h80, 8'h00, 8'h00};

  logic i_clock = 1'h0;
  logic i_arst_n = 1'h0;
  ieb_sfr_req_s sfr = '0;
  ieb_bit_req_s bitq = '0;
  ieb_pending_s pend = '0;
  logic auto_en = 1'h0;
  logic ret = 1'h0;
  logic take;
  logic reti;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic bit_rdata;
  logic [14:0] req;
  logic [14:0] req_high;
  ieb_grant_s grant;
  ieb_src_e last_src;
  logic [1:0] depth;
  int err_count = 0;
  int n_checks = 0;

  always #2.5 i_clock = ~i_clock;

  ieb_irq_bank i_ieb_irq_bank (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_sfr(sfr),
    .o_sfr_rdata(sfr_rdata), .o_sfr_hit(sfr_hit), .i_bit(bitq), .o_bit_rdata(bit_rdata),
    .i_pend(pend), .i_take(take), .i_reti(reti), .o_req(req), .o_req_high(req_high),
    .o_grant(grant));

  ieb_core_model i_ieb_core_model (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_grant(grant),
    .i_auto(auto_en), .i_ret(ret), .o_take(take), .o_reti(reti), .o_last_src(last_src),
    .o_depth(depth));

  function automatic logic [14:0] f_req(logic [7:0] ie, logic [7:0] eie, ieb_pending_s p);
    logic [14:0] s;
    s = {p.timer_c_high_overflow | p.timer_c_low_overflow,
      p.comparator_b_rise_flag | p.comparator_b_fall_flag,
      p.comparator_a_rise_flag | p.comparator_a_fall_flag, p.counter_array_req,
      p.conversion_done_flag, p.window_hit_flag, p.clock_alarm_req, p.two_wire_req,
      p.serial_periph_a_req, p.timer_b_high_overflow | p.timer_b_low_overflow,
      p.async_serial_req, p.timer_one_overflow, p.ext_pin_b_input, p.timer_zero_overflow,
      p.ext_pin_a_input};
    return ie[7] ? (s & {eie, ie[6:0]}) : 15'h0000;
  endfunction

  // Idle service: high level first, then lowest vector index
  function automatic logic [5:0] f_grant(logic [14:0] r, logic [14:0] rh);
    logic [14:0] v;
    f_grant = 6'h00;
    v = (rh != 15'h0000) ? rh : r;
    for (int i = 14; i >= 0; i--)
    begin
      if (v[i])
        f_grant = {1'h1, rh != 15'h0000, 4'(i)};
    end
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge i_clock) i_arst_n <= 1'h0;
    repeat (12) @(posedge i_clock);
    i_arst_n <= 1'h1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) sfr <= '{1'h0, 1'h1, a, d};
    @(posedge i_clock) sfr.wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge i_clock) sfr <= '{1'h1, 1'h0, a, 8'h00};
    @(posedge i_clock) sfr.rd <= 1'h0;
    @(negedge i_clock);
    chk(sfr_rdata, exp, "byte read");
    chk(sfr_hit, hit, "read hit");
  endtask

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge i_clock) bitq <= '{1'h0, 1'h1, a, v};
    @(posedge i_clock) bitq.wr <= 1'h0;
  endtask

  task automatic br(input logic [7:0] a, input logic exp);
    @(posedge i_clock) bitq <= '{1'h1, 1'h0, a, 1'h0};
    @(posedge i_clock) bitq.rd <= 1'h0;
    @(negedge i_clock);
    chk(bit_rdata, exp, "bit read");
  endtask

  task automatic setregs(input logic [7:0] ie, ip, eie, eip);
    logic [7:0] v [4];
    v = '{ie, ip, eie, eip};
    for (int k = 0; k < 4; k++)
      wr(ADDRS[k], v[k]);
    for (int k = 0; k < 4; k++)
      rd_chk(ADDRS[k], (k == 1) ? (v[k] | 8'h80) : v[k], 1'h1);
  endtask

  task automatic ret_pulse();
    @(posedge i_clock) ret <= 1'h1;
    @(posedge i_clock) ret <= 1'h0;
  endtask

  // Bounded wait for the core model to reach a service depth
  task automatic wait_depth(input logic [1:0] d);
    repeat (40)
    begin
      @(negedge i_clock);
      if (depth === d)
        break;
    end
    if (depth !== d)
    begin
      chk(depth, d, "service depth not reached");
      results();
    end
  endtask

  task automatic blocked(input logic [1:0] d);
    repeat (10) @(posedge i_clock);
    @(negedge i_clock);
    chk(depth, d, "unexpected take");
    chk(grant.valid, 1'h0, "grant offered");
  endtask

  initial
  begin
    logic [7:0] ie, ip, eie, eip, e, pr;
    logic [14:0] r, rh;
    ieb_pending_s p;
    void'($urandom(32'h6042469B));
    do_reset();
    for (int k = 0; k < 4; k++)
      rd_chk(ADDRS[k], RSTS[k], 1'h1);
    // Unmapped places, one of them written first
    wr(8'hE7, 8'h5A);
    rd_chk(8'hE7, 8'h00, 1'h0);
    rd_chk(8'hA9, 8'h00, 1'h0);
    // Bit-addressable writes build both main registers bit by bit
    for (int k = 0; k < 8; k++)
    begin
      e[k] = 1'($urandom);
      pr[k] = ~e[k];
      bw(8'hA8 + 8'(k), e[k]);
      bw(8'hB8 + 8'(k), pr[k]);
    end
    pr[7] = 1'h1;
    rd_chk(8'hA8, e, 1'h1);
    rd_chk(8'hB8, pr, 1'h1);
    for (int k = 0; k < 8; k++)
    begin
      br(8'hA8 + 8'(k), e[k]);
      br(8'hB8 + 8'(k), pr[k]);
    end
    br(8'hE6, 1'h0);
    // Gating and ranking with random masks, priorities and flags
    for (int n = 0; n < 120; n++)
    begin
      ie = 8'($urandom);
      ip = 8'($urandom);
      eie = 8'($urandom);
      eip = 8'($urandom);
      p = ieb_pending_s'(19'($urandom & $urandom));
      if (n == 0)
      begin
        ie = 8'h7F;
        eie = 8'hFF;
        p = '1;
      end
      if (n == 1)
      begin
        ie = 8'hFF;
        eie = 8'hFF;
        p = '1;
      end
      setregs(ie, ip, eie, eip);
      @(posedge i_clock) pend <= p;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      r = f_req(ie, eie, p);
      rh = r & {eip, ip[6:0]};
      chk(req, r, "masked requests");
      chk(req_high, rh, "high requests");
      chk(grant, f_grant(r, rh), "idle grant");
    end
    // Preemption: external pin a high, the rest low until external pin b is made high
    @(posedge i_clock) pend <= '0;
    setregs(8'hFF, 8'h01, 8'h00, 8'h00);
    auto_en <= 1'h1;
    @(posedge i_clock) pend.timer_zero_overflow <= 1'h1;
    wait_depth(2'h1);
    chk(last_src, IEB_SRC_TIMER_ZERO, "low taken");
    @(posedge i_clock)
    begin
      pend.timer_zero_overflow <= 1'h0;
      pend.ext_pin_b_input <= 1'h1;
    end
    blocked(2'h1);
    @(posedge i_clock) pend.ext_pin_a_input <= 1'h1;
    wait_depth(2'h2);
    chk(last_src, IEB_SRC_EXT_PIN_A, "high preempts");
    @(posedge i_clock) pend.ext_pin_a_input <= 1'h0;
    wr(8'hB8, 8'h05);
    blocked(2'h2);
    ret_pulse();
    wait_depth(2'h1);
    wait_depth(2'h2);
    chk(last_src, IEB_SRC_EXT_PIN_B, "high in low service");
    @(posedge i_clock) pend <= '0;
    ret_pulse();
    wait_depth(2'h1);
    ret_pulse();
    wait_depth(2'h0);
    // Reset in mid-run restores every register
    do_reset();
    for (int k = 0; k < 4; k++)
      rd_chk(ADDRS[k], RSTS[k], 1'h1);
    results();
  end
endmodule

`default_nettype wire
